// [shared/mfrs_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mfrs_if;
  logic rst_n;
  logic bus_clk;
  logic cmd_valid;
  logic [5:0] cmd_index;
  logic [31:0] cmd_arg;
  logic resp_valid;
  logic strobe;
  logic strobe_oe;
  logic hs400;
  logic ready;
  modport host_end (output rst_n, output bus_clk, output cmd_valid, output cmd_index,
    output cmd_arg, output hs400, input resp_valid, input strobe, input strobe_oe, input ready);
  modport dev_end (input rst_n, input bus_clk, input cmd_valid, input cmd_index,
    input cmd_arg, input hs400, output resp_valid, output strobe, output strobe_oe, output ready);
endinterface
`default_nettype wire

// [shared/mfrs_pkg.sv]
package mfrs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned RST_LOW_MIN_US = 1;
  localparam int unsigned RST_HIGH_MIN_US = 1;
  localparam int unsigned RST_TO_CMD_MIN_US = 200;
  localparam int unsigned RST_LOW_CYC = (RST_LOW_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned RST_HIGH_CYC = (RST_HIGH_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned RST_TO_CMD_CYC = (RST_TO_CMD_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned INIT_CLK_CYC = 74;
  localparam int unsigned CNT_W = 16;
  // ----------------------------------------
  // Pre-load size limit
  // ----------------------------------------
  localparam logic [31:0] PRELOAD_LIMIT_RST = 32'h0000_1000;
  localparam logic [31:0] PRELOAD_LIMIT_ENH = 32'h0000_0800;
  // ----------------------------------------
  // Strobe source selection
  // ----------------------------------------
  typedef enum logic [1:0] {MFRS_DS_IDLE, MFRS_DS_RESP, MFRS_DS_RDATA, MFRS_DS_CRC} mfrs_ds_src_t;
endpackage

// [testbench/mfrs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module mfrs_checker
  import mfrs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic rst_n,
  input wire logic bus_clk,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_arg,
  input wire logic resp_valid,
  input wire logic strobe,
  input wire logic strobe_oe,
  input wire logic hs400,
  input wire logic ready
);
  // ----------------------------------------
  // Reset pulse and clock counters
  // ----------------------------------------
  logic [15:0] lo_c, up_c, bc_c;
  logic bclk_q;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // up_c and bc_c saturate so a long idle stretch never wraps into a false short gap; lo_c wraps
  always_ff @(posedge clk_sys_in)
  begin
    bclk_q <= bus_clk;
    lo_c <= (sys_rst_in || rst_n) ? 16'h0 : lo_c + 16'h1;
    up_c <= sys_rst_in ? 16'hFFFF : (!rst_n ? 16'h0 : up_c + {15'h0, ~&up_c});
    bc_c <= sys_rst_in ? 16'hFFFF : (!rst_n ? 16'h0 : bc_c + {15'h0, bus_clk & ~bclk_q & ~&bc_c});
  end
  sequence rst_end_s;
    !rst_n ##1 rst_n;
  endsequence
  resp_follow_a: assert property (cmd_valid |=> resp_valid)
    else $error("response missing after command");
  resp_cause_a: assert property (resp_valid |-> $past(cmd_valid))
    else $error("response without command");
  resp_strobe_a: assert property (hs400 && cmd_valid |=> strobe != $past(strobe))
    else $error("strobe did not toggle with response");
  oe_on_a: assert property (hs400 [*2] |-> strobe_oe)
    else $error("strobe not driven in fast mode");
  oe_idle_a: assert property (!hs400 [*2] |-> !strobe_oe)
    else $error("strobe driven outside fast mode");
  rst_low_a: assert property (rst_end_s |-> lo_c >= RST_LOW_CYC)
    else $error("reset pulse too short");
  rst_gap_a: assert property ($fell(rst_n) |-> up_c >= RST_HIGH_CYC)
    else $error("reset high gap too short");
  cmd_wait_a: assert property (cmd_valid |-> rst_n && up_c >= RST_TO_CMD_CYC)
    else $error("command too soon after reset");
  init_clk_a: assert property (cmd_valid && (cmd_index == 6'h01 || cmd_index == 6'h00
    && cmd_arg == 32'h0FFFFFFA) |-> bc_c >= INIT_CLK_CYC)
    else $error("too few bus clocks before init command");
  ready_track_a: assert property (ready == $past(rst_n))
    else $error("ready does not follow sampled reset pin");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mfrs_pkg::*;
;
  // ----------------------------------------
  // Both ends joined, driven from the user sides
  // ----------------------------------------
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, lo, en, rd, crc, eset, preq, rreq, creq, hs;
  logic irst, acc, busy, ok, s;
  logic [5:0] idx;
  logic [31:0] elim, pbytes, carg, lim, lim_exp, used;
  int mismatches, check_count, n;
  always #10 clk_sys_in = ~clk_sys_in;
  mfrs_if bus();
  mfrs_host mfrs_host_i(.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(bus),
    .reset_req_in(rreq), .cmd_req_in(creq), .cmd_index_in(idx), .cmd_arg_in(carg),
    .hs400_in(hs), .busy_out(busy), .cmd_ok_out(ok));
  mfrs_device mfrs_device_i(.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(bus),
    .rst_fn_loaded_in(lo), .rst_fn_enable_in(en), .rdata_active_in(rd), .crc_token_in(crc),
    .enh_part_set_in(eset), .enh_limit_in(elim), .preload_req_in(preq),
    .preload_bytes_in(pbytes), .internal_reset_out(irst), .preload_accept_out(acc),
    .preload_limit_out(lim));
  mfrs_checker mfrs_checker_i(.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .rst_n(bus.rst_n), .bus_clk(bus.bus_clk), .cmd_valid(bus.cmd_valid),
    .cmd_index(bus.cmd_index), .cmd_arg(bus.cmd_arg), .resp_valid(bus.resp_valid),
    .strobe(bus.strobe), .strobe_oe(bus.strobe_oe), .hs400(bus.hs400), .ready(bus.ready));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask
  function automatic logic fits(input logic [31:0] u, input logic [31:0] b);
    return (u + b) <= lim_exp;
  endfunction
  // Strobe toggles with a response only in fast mode, else it rests low
  function automatic logic exp_strobe(input logic m, input logic prev);
    return m ? ~prev : 1'b0;
  endfunction
  // Bounded waits: a stuck busy or missing answer ends the run
  task automatic hw_reset(output int pulses);
    pulses = 0;
    rreq = 1'b1;
    tick();
    rreq = 1'b0;
    for (int i = 0; i < 12000 && (busy !== 1'b0 || i < 2); i++)
    begin
      tick();
      pulses += int'(irst === 1'b1);
    end
    chk("busy", 32'h0, {31'h0, busy});
    if (busy !== 1'b0)
      wrap_up();
  endtask
  task automatic send_cmd(input logic [5:0] i, input logic [31:0] a);
    logic s0;
    idx = i;
    carg = a;
    creq = 1'b1;
    tick();
    creq = 1'b0;
    for (int k = 0; k < 50 && ok !== 1'b1; k++)
      tick();
    chk("cmd_ok", 32'h1, {31'h0, ok});
    if (ok !== 1'b1)
      wrap_up();
    s0 = bus.strobe;
    tick();
    chk("resp_valid", 32'h1, {31'h0, bus.resp_valid});
    chk("strobe", {31'h0, exp_strobe(hs, s0)}, {31'h0, bus.strobe});
    chk("strobe_oe", {31'h0, hs}, {31'h0, bus.strobe_oe});
  endtask
  task automatic preload(input logic [31:0] b);
    logic e;
    e = fits(used, b);
    pbytes = b;
    preq = 1'b1;
    tick();
    preq = 1'b0;
    chk("accept", {31'h0, e}, {31'h0, acc});
    if (e)
      used += b;
    tick();
  endtask
  initial
  begin
    {lo, en, rd, crc, eset, preq, rreq, creq, hs} = '0;
    {idx, carg, elim, pbytes, used} = '0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(4));
    repeat (5) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      {lo, en} = (k == 0) ? 2'b01 : ((k == 1) ? 2'b10 : 2'b11);
      hw_reset(n);
      chk("reset_pulses", (k == 2) ? 32'h1 : 32'h0, n);
    end
    lim_exp = PRELOAD_LIMIT_RST;
    chk("limit", lim_exp, lim);
    repeat (6) preload($urandom_range(32'h7FF));
    preload(lim_exp - used + 32'h1);
    preload(lim_exp - used);
    elim = $urandom_range(32'hFFF, 32'h100);
    eset = 1'b1;
    tick();
    eset = 1'b0;
    tick();
    lim_exp = elim;
    chk("limit", lim_exp, lim);
    preload(32'h10);
    hs = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      {rd, crc} = 2'(k);
      tick();
      tick();
      s = bus.strobe;
      tick();
      chk("strobe", {31'h0, (k == 0) ? s : ~s}, {31'h0, bus.strobe});
    end
    {rd, crc} = 2'b00;
    send_cmd(6'h01, 32'h0);
    send_cmd(6'h00, 32'h0FFFFFFA);
    repeat (6) send_cmd(6'($urandom_range(63)), $urandom());
    hs = 1'b0;
    repeat (3) send_cmd(6'($urandom_range(63)), $urandom());
    wrap_up();
  end
endmodule
`default_nettype wire

// [verilog/mfrs_device.sv]
// Contract
// [R1] HS400: strobe accompanies every command response
// [R2] HS400 data: strobe only for read/CRC token
// [R3] Internal reset starts on reset rising edge
// [R4] Host holds reset low and high 1 us
// [R5] Host waits 200 us before commands
// [R6] Host gives 74 clocks before CMD1/CMD0
// [R7] Reset ignored until enable setting loaded
// [R8] Pre-load data capped at reported limit
// [R9] Limit updates when enhanced partition configured
`timescale 1ns/1ps
`default_nettype none
module mfrs_device
  import mfrs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  mfrs_if.dev_end link,
  input wire logic rst_fn_loaded_in,
  input wire logic rst_fn_enable_in,
  input wire logic rdata_active_in,
  input wire logic crc_token_in,
  input wire logic enh_part_set_in,
  input wire logic [31:0] enh_limit_in,
  input wire logic preload_req_in,
  input wire logic [31:0] preload_bytes_in,
  output logic internal_reset_out,
  output logic preload_accept_out,
  output logic [31:0] preload_limit_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic rst_q, next_rst_q;
  logic ireset, next_ireset;
  logic resp, next_resp;
  logic ds, next_ds;
  logic ds_oe, next_ds_oe;
  logic acc, next_acc;
  logic [31:0] limit, next_limit;
  logic [31:0] used, next_used;

  always_comb
  begin
    next_rst_q = link.rst_n;
    next_ireset = 1'b0;
    // Detection only after the enable setting is loaded
    if (rst_fn_loaded_in && rst_fn_enable_in && link.rst_n && !rst_q) // [R3] [R7]
      next_ireset = 1'b1;
    next_resp = link.cmd_valid && !ireset;
    next_ds = 1'b0;
    next_ds_oe = 1'b0;
    if (link.hs400)
    begin
      next_ds_oe = 1'b1;
      if (link.cmd_valid) // [R1]
        next_ds = !ds;
      else if (rdata_active_in || crc_token_in) // [R2]
        next_ds = !ds;
    end
    next_limit = limit;
    if (enh_part_set_in) // [R9]
      next_limit = enh_limit_in;
    next_used = used;
    next_acc = 1'b0;
    if (preload_req_in && ({1'b0, used} + {1'b0, preload_bytes_in} <= {1'b0, limit})) // [R8]
    begin
      next_acc = 1'b1;
      next_used = used + preload_bytes_in;
    end
    if (ireset)
      next_used = 32'h0000_0000;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rst_q <= 1'b1;
      ireset <= 1'b0;
      resp <= 1'b0;
      ds <= 1'b0;
      ds_oe <= 1'b0;
      acc <= 1'b0;
      limit <= PRELOAD_LIMIT_RST;
      used <= 32'h0000_0000;
    end
    else
    begin
      rst_q <= next_rst_q;
      ireset <= next_ireset;
      resp <= next_resp;
      ds <= next_ds;
      ds_oe <= next_ds_oe;
      acc <= next_acc;
      limit <= next_limit;
      used <= next_used;
    end
  end

  assign link.resp_valid = resp;
  assign link.strobe = ds;
  assign link.strobe_oe = ds_oe;
  assign link.ready = rst_q;
  assign internal_reset_out = ireset;
  assign preload_accept_out = acc;
  assign preload_limit_out = limit;
endmodule
`default_nettype wire

// [verilog/mfrs_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mfrs_host
  import mfrs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  mfrs_if.host_end link,
  input wire logic reset_req_in,
  input wire logic cmd_req_in,
  input wire logic [5:0] cmd_index_in,
  input wire logic [31:0] cmd_arg_in,
  input wire logic hs400_in,
  output logic busy_out,
  output logic cmd_ok_out
);
  typedef enum logic [1:0] {MFRS_H_IDLE, MFRS_H_LOW, MFRS_H_WAIT} mfrs_hst_t;
  mfrs_hst_t st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] gap, next_gap;
  logic [6:0] clks, next_clks;
  logic rstn, next_rstn;
  logic ck, next_ck;
  logic cv, next_cv;
  logic [5:0] ci, next_ci;
  logic [31:0] ca, next_ca;
  // Registered so that every output leaves a flip-flop
  logic busy, next_busy;
  logic hs, next_hs;

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_gap = (gap != '0) ? gap - 1'b1 : gap;
    next_rstn = rstn;
    next_ck = !ck;
    next_clks = (ck && clks != 7'h7F) ? clks + 7'h01 : clks;
    next_cv = 1'b0;
    next_ci = ci;
    next_ca = cmd_arg_in;
    case (st)
      MFRS_H_IDLE:
        if (reset_req_in && gap == '0) // [R4]
        begin
          next_st = MFRS_H_LOW;
          next_rstn = 1'b0;
          next_cnt = CNT_W'(RST_LOW_CYC);
        end
        else if (cmd_req_in)
        begin
          next_cv = 1'b1;
          next_ci = cmd_index_in;
        end
      MFRS_H_LOW:
        if (cnt <= 1) // [R4]
        begin
          next_st = MFRS_H_WAIT;
          next_rstn = 1'b1;
          next_cnt = CNT_W'(RST_TO_CMD_CYC);
          next_gap = CNT_W'(RST_HIGH_CYC);
          next_clks = 7'h00;
        end
        else
          next_cnt = cnt - 1'b1;
      MFRS_H_WAIT:
        // Both the wait and the clock count must elapse
        if (cnt <= 1 && clks >= 7'(INIT_CLK_CYC)) // [R5] [R6]
          next_st = MFRS_H_IDLE;
        else if (cnt > 1)
          next_cnt = cnt - 1'b1;
      default:
        next_st = MFRS_H_IDLE;
    endcase
    next_busy = (next_st != MFRS_H_IDLE);
    next_hs = hs400_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st <= MFRS_H_IDLE;
      cnt <= '0;
      gap <= '0;
      clks <= 7'h00;
      rstn <= 1'b1;
      ck <= 1'b0;
      cv <= 1'b0;
      ci <= 6'h00;
      ca <= 32'h0000_0000;
      busy <= 1'b0;
      hs <= 1'b0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      gap <= next_gap;
      clks <= next_clks;
      rstn <= next_rstn;
      ck <= next_ck;
      cv <= next_cv;
      ci <= next_ci;
      ca <= next_ca;
      busy <= next_busy;
      hs <= next_hs;
    end
  end

  assign link.rst_n = rstn;
  assign link.bus_clk = ck;
  assign link.cmd_valid = cv;
  assign link.cmd_index = ci;
  assign link.cmd_arg = ca;
  assign link.hs400 = hs;
  assign busy_out = busy;
  assign cmd_ok_out = cv;
endmodule
`default_nettype wire
